// ---- pla_consts.svh ----
// Constants for the parameter lock and analog source select block.
`ifndef PLA_CONSTS_SVH
`define PLA_CONSTS_SVH

`define PLA_ADDR_W       4
`define PLA_DATA_W       16
`define PLA_PARAM_AW     8
`define PLA_SLOTS        6
`define PLA_CODE_W       5
`define PLA_ADC_W        10
`define PLA_FREQ_W       11

`define PLA_FN_LOCK      5'h0f
`define PLA_FN_ASEL      5'h10
`define PLA_FN_NONE      5'h1f
`define PLA_FSRC_ANALOG  2'h1

`define PLA_OFS_SLOT0    4'h0
`define PLA_OFS_SLOT5    4'h5
`define PLA_OFS_CTRL     4'h6
`define PLA_OFS_STATUS   4'h7
`define PLA_OFS_FREQ     4'h8

`define PLA_CTRL_SCOPE   0
`define PLA_CTRL_OPLOCK  1
`define PLA_CTRL_FSRC_LO 2
`define PLA_CTRL_FSRC_HI 3
`define PLA_CTRL_RST     4'h4
`define PLA_FREQ_RST     11'h000

`endif

// ---- pla_pkg.sv ----
// Types shared by the parameter lock and analog source select block.
package pla_pkg;
`include "pla_consts.svh"

  typedef struct packed {
    logic                      valid;
    logic                      remote;
    logic                      is_freq;
    logic [`PLA_PARAM_AW-1:0]  addr;
    logic [`PLA_DATA_W-1:0]    data;
  } pla_edit_req_s;

  typedef struct packed {
    logic                      commit;
    logic                      refused;
    logic                      remote;
    logic                      is_freq;
    logic [`PLA_PARAM_AW-1:0]  addr;
    logic [`PLA_DATA_W-1:0]    data;
  } pla_edit_rsp_s;

  typedef enum logic [1:0] {
    PLA_ST_IDLE = 2'b01,
    PLA_ST_RESP = 2'b10
  } pla_state_e;

endpackage

// ---- pla_sync.sv ----
// Two flip-flop synchroniser for a group of terminal levels.
module pla_sync
  import pla_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule // pla_sync

// ---- pla_slot_match.sv ----
// Finds whether a terminal function is assigned to a slot and is active.
module pla_slot_match
  import pla_pkg::*;
#(
  parameter logic [`PLA_CODE_W-1:0] FN_CODE = `PLA_FN_NONE
) (
  input  wire logic [`PLA_SLOTS-1:0][`PLA_CODE_W-1:0] slot_codes_in,
  input  wire logic [`PLA_SLOTS-1:0]                  levels_in,
  output logic                                        assigned_out,
  output logic                                        active_out
);

  always_comb begin
    assigned_out = 1'b0;
    active_out   = 1'b0;
    for (int i = 0; i < `PLA_SLOTS; i++) begin
      if (slot_codes_in[i] == FN_CODE) begin // [R6]
        assigned_out = 1'b1;
        active_out   = active_out | levels_in[i]; // [R11]
      end
    end
  end

endmodule // pla_slot_match

// ---- pla_top.sv ----
// Parameter edit lock and analog frequency source selection.
//
// Overview of operation
// R1 - Lock input active refuses keypad and remote edits.
// R2 - Lock inactive: edits accepted and committed.
// R3 - Frequency stays editable under lock by default.
// R4 - Scope setting chooses frequency exempt or frozen.
// R5 - Operator setting applies lock without any terminal.
// R6 - Lock function assignable to any of six slots.
// R7 - Select active: reference from current input.
// R8 - Select inactive: reference from voltage input.
// R9 - Selection matters only with analog source setting.
// R10 - Select unassigned: reference is voltage plus current.
// R11 - Both inputs level sensitive, release restores behaviour.
//
// Strobed register access and the address map were left to the implementer.
module pla_top
  import pla_pkg::*;
(
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_in,
  input  wire logic [`PLA_ADDR_W-1:0]   reg_addr_in,
  input  wire logic [`PLA_DATA_W-1:0]   reg_wdata_in,
  input  wire logic                     reg_write_in,
  input  wire logic                     reg_read_in,
  output logic      [`PLA_DATA_W-1:0]   reg_rdata_out,
  input  wire logic [`PLA_SLOTS-1:0]    input_pins_in,
  input  wire logic [`PLA_ADC_W-1:0]    voltage_adc_in,
  input  wire logic [`PLA_ADC_W-1:0]    current_adc_in,
  input  wire pla_edit_req_s            edit_req_in,
  output logic                          edit_ready_out,
  output pla_edit_rsp_s                 edit_rsp_out,
  output logic      [`PLA_FREQ_W-1:0]   freq_ref_out,
  output logic                          param_edit_lock_out
);

  // Terminal levels and decoded functions.
  logic [`PLA_SLOTS-1:0]                  pins_sync;
  logic                                   lock_assigned;
  logic                                   lock_active;
  logic                                   asel_assigned;
  logic                                   asel_active;

  // Software visible settings.
  logic [`PLA_SLOTS-1:0][`PLA_CODE_W-1:0] slot_code_ff;
  logic [`PLA_SLOTS-1:0][`PLA_CODE_W-1:0] nxt_slot_code;
  logic                                   lock_scope_setting_ff;
  logic                                   nxt_lock_scope_setting;
  logic                                   oper_lock_ff;
  logic                                   nxt_oper_lock;
  logic [1:0]                             frequency_source_setting_ff;
  logic [1:0]                             nxt_frequency_source_setting;
  logic [`PLA_FREQ_W-1:0]                 freq_set_ff;
  logic [`PLA_FREQ_W-1:0]                 nxt_freq_set;
  logic [`PLA_DATA_W-1:0]                 rdata_ff;
  logic [`PLA_DATA_W-1:0]                 nxt_rdata;
  logic                                   wr_slot;
  logic                                   wr_ctrl;
  logic                                   wr_freq;
  logic [`PLA_DATA_W-1:0]                 ctrl_word;
  logic [`PLA_DATA_W-1:0]                 status_word;

  // Edit handling.
  pla_state_e                             state_ff;
  pla_state_e                             nxt_state;
  pla_edit_req_s                          req_ff;
  pla_edit_req_s                          nxt_req;
  pla_edit_rsp_s                          rsp_ff;
  pla_edit_rsp_s                          nxt_rsp;
  logic                                   ready_ff;
  logic                                   nxt_ready;
  logic                                   terminal_lock;
  logic                                   locked;
  logic                                   refuse;
  logic                                   freq_edit_wr;

  // Frequency reference.
  logic [`PLA_FREQ_W-1:0]                 freq_ref_ff;
  logic [`PLA_FREQ_W-1:0]                 nxt_freq_ref;
  logic [`PLA_FREQ_W-1:0]                 analog_sum;
  logic [`PLA_FREQ_W-1:0]                 analog_pick;
  logic                                   lock_out_ff;
  logic                                   nxt_lock_out;

  // Terminal pins come from switches outside the clock domain.
  pla_sync #(
    .WIDTH (`PLA_SLOTS)
  ) u_pin_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    (input_pins_in),
    .sync_out    (pins_sync)
  );

  pla_slot_match #(
    .FN_CODE (`PLA_FN_LOCK)
  ) u_lock_match (
    .slot_codes_in (slot_code_ff),
    .levels_in     (pins_sync),
    .assigned_out  (lock_assigned),
    .active_out    (lock_active)
  );

  pla_slot_match #(
    .FN_CODE (`PLA_FN_ASEL)
  ) u_asel_match (
    .slot_codes_in (slot_code_ff),
    .levels_in     (pins_sync),
    .assigned_out  (asel_assigned),
    .active_out    (asel_active)
  );

  // The lock follows the terminal level each cycle, so no unlock command
  // exists; releasing the terminal or writing another code into its slot are the only ways back.
  always_comb begin
    terminal_lock = lock_assigned & lock_active; // [R1] [R6] [R11]
    locked        = terminal_lock | oper_lock_ff; // [R5]
  end

  // A request is judged against the lock level at the moment it is
  // answered, not when it was taken.
  always_comb begin
    if (req_ff.is_freq) begin
      refuse = locked & lock_scope_setting_ff; // [R3] [R4]
    end else begin
      refuse = locked; // [R1]
    end
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_req      = req_ff;
    nxt_rsp      = '0;
    nxt_ready    = ready_ff;
    freq_edit_wr = 1'b0;
    case (state_ff)
      PLA_ST_IDLE: begin
        nxt_ready = 1'b1;
        if (edit_req_in.valid) begin
          nxt_req   = edit_req_in;
          nxt_state = PLA_ST_RESP;
          nxt_ready = 1'b0;
        end
      end
      PLA_ST_RESP: begin
        nxt_rsp.remote  = req_ff.remote;
        nxt_rsp.is_freq = req_ff.is_freq;
        nxt_rsp.addr    = req_ff.addr;
        nxt_rsp.data    = req_ff.data;
        nxt_rsp.refused = refuse; // [R1]
        nxt_rsp.commit  = ~refuse; // [R2]
        freq_edit_wr    = ~refuse & req_ff.is_freq; // [R3]
        nxt_state       = PLA_ST_IDLE;
        nxt_ready       = 1'b1;
      end
      default: begin
        nxt_state = PLA_ST_IDLE;
        nxt_ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_ff <= PLA_ST_IDLE;
      req_ff   <= '0;
      rsp_ff   <= '0;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff   <= nxt_req;
      rsp_ff   <= nxt_rsp;
      ready_ff <= nxt_ready;
    end
  end

  // Write decode. Bus writes are never locked: the lock guards only the
  // keypad and remote edit path.
  always_comb begin
    wr_slot = 1'b0;
    wr_ctrl = 1'b0;
    wr_freq = 1'b0;
    if (reg_write_in) begin
      case (reg_addr_in)
        `PLA_OFS_CTRL: begin
          wr_ctrl = 1'b1;
        end
        `PLA_OFS_FREQ: begin
          wr_freq = 1'b1;
        end
        default: begin
          wr_slot = (reg_addr_in <= `PLA_OFS_SLOT5);
        end
      endcase
    end
  end

  always_comb begin
    nxt_slot_code = slot_code_ff;
    if (wr_slot) begin
      nxt_slot_code[reg_addr_in] = reg_wdata_in[`PLA_CODE_W-1:0]; // [R6]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < `PLA_SLOTS; i++) begin
        slot_code_ff[i] <= `PLA_FN_NONE;
      end
    end else begin
      slot_code_ff <= nxt_slot_code;
    end
  end

  always_comb begin
    nxt_lock_scope_setting       = lock_scope_setting_ff;
    nxt_oper_lock                = oper_lock_ff;
    nxt_frequency_source_setting = frequency_source_setting_ff;
    if (wr_ctrl) begin
      nxt_lock_scope_setting = reg_wdata_in[`PLA_CTRL_SCOPE]; // [R4]
      nxt_oper_lock          = reg_wdata_in[`PLA_CTRL_OPLOCK]; // [R5]
      nxt_frequency_source_setting =
        reg_wdata_in[`PLA_CTRL_FSRC_HI:`PLA_CTRL_FSRC_LO]; // [R9]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      lock_scope_setting_ff       <= 1'(`PLA_CTRL_RST >> `PLA_CTRL_SCOPE);
      oper_lock_ff                <= 1'(`PLA_CTRL_RST >> `PLA_CTRL_OPLOCK);
      frequency_source_setting_ff <= 2'(`PLA_CTRL_RST >> `PLA_CTRL_FSRC_LO);
    end else begin
      lock_scope_setting_ff       <= nxt_lock_scope_setting;
      oper_lock_ff                <= nxt_oper_lock;
      frequency_source_setting_ff <= nxt_frequency_source_setting;
    end
  end

  // A bus write to the frequency word wins over an edit committed in the
  // same cycle; software is the more recent intent.
  always_comb begin
    nxt_freq_set = freq_set_ff;
    if (freq_edit_wr) begin
      nxt_freq_set = req_ff.data[`PLA_FREQ_W-1:0]; // [R3]
    end
    if (wr_freq) begin
      nxt_freq_set = reg_wdata_in[`PLA_FREQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      freq_set_ff <= `PLA_FREQ_RST;
    end else begin
      freq_set_ff <= nxt_freq_set;
    end
  end

  // Read data is zero outside its one cycle, so a shared bus can OR the
  // answers of several slaves without a multiplexer.
  always_comb begin
    ctrl_word   = '0;
    status_word = '0;
    ctrl_word[`PLA_CTRL_SCOPE]  = lock_scope_setting_ff;
    ctrl_word[`PLA_CTRL_OPLOCK] = oper_lock_ff;
    ctrl_word[`PLA_CTRL_FSRC_HI:`PLA_CTRL_FSRC_LO] =
      frequency_source_setting_ff;
    status_word[3:0] = {lock_assigned, asel_assigned, asel_active, locked};
    nxt_rdata = '0;
    if (reg_read_in) begin
      case (reg_addr_in)
        `PLA_OFS_CTRL: begin
          nxt_rdata = ctrl_word;
        end
        `PLA_OFS_STATUS: begin
          nxt_rdata = status_word;
        end
        `PLA_OFS_FREQ: begin
          nxt_rdata[`PLA_FREQ_W-1:0] = freq_set_ff;
        end
        default: begin
          if (reg_addr_in <= `PLA_OFS_SLOT5) begin
            nxt_rdata[`PLA_CODE_W-1:0] = slot_code_ff[reg_addr_in];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // The sum cannot overflow: one extra bit holds two full-scale inputs.
  always_comb begin
    analog_sum = {1'b0, voltage_adc_in} + {1'b0, current_adc_in}; // [R10]
    if (!asel_assigned) begin
      analog_pick = analog_sum; // [R10]
    end else if (asel_active) begin
      analog_pick = {1'b0, current_adc_in}; // [R7] [R11]
    end else begin
      analog_pick = {1'b0, voltage_adc_in}; // [R8]
    end
    if (frequency_source_setting_ff == `PLA_FSRC_ANALOG) begin
      nxt_freq_ref = analog_pick; // [R9]
    end else begin
      nxt_freq_ref = freq_set_ff; // [R9]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      freq_ref_ff <= '0;
    end else begin
      freq_ref_ff <= nxt_freq_ref;
    end
  end

  // Registered beside the edit answer, so the pin shows the very level
  // that each answer was judged by.
  always_comb begin
    nxt_lock_out = locked; // [R1] [R5]
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      lock_out_ff <= 1'b0;
    end else begin
      lock_out_ff <= nxt_lock_out;
    end
  end

  assign reg_rdata_out       = rdata_ff;
  assign edit_ready_out      = ready_ff;
  assign edit_rsp_out        = rsp_ff;
  assign freq_ref_out        = freq_ref_ff;
  assign param_edit_lock_out = lock_out_ff;

endmodule // pla_top

// ---- pla_top_asserts.sv ----
// Checker of the edit port and read port timing of the lock block.
`include "pla_consts.svh"
module pla_top_asserts
  import pla_pkg::*;
(
  input wire logic                   core_clk_in,
  input wire logic                   reset_in,
  input wire logic                   reg_read_in,
  input wire logic [`PLA_DATA_W-1:0] reg_rdata_out,
  input wire pla_edit_req_s          edit_req_in,
  input wire logic                   edit_ready_out,
  input wire pla_edit_rsp_s          edit_rsp_out,
  input wire logic                   param_edit_lock_out
);
  wire logic ans_w = edit_rsp_out.commit || edit_rsp_out.refused;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_take;
    edit_req_in.valid && edit_ready_out;
  endsequence
  sequence s_gap;
    !edit_ready_out ##1 edit_ready_out;
  endsequence
  AST_RSP_LAT: assert property (s_take |-> ##2 ans_w)
    else $error("edit answer not two cycles after the request");
  AST_READY_GAP: assert property (s_take |=> s_gap)
    else $error("edit ready did not drop for one cycle");
  AST_NO_ORPHAN: assert property (ans_w |-> $past(edit_req_in.valid, 2))
    else $error("edit answer without a request");
  AST_REFUSE_LOCKED: assert property (
    edit_rsp_out.refused |-> param_edit_lock_out)
    else $error("edit refused while unlocked");
  AST_COMMIT_FREE: assert property (
    ans_w && !param_edit_lock_out |-> edit_rsp_out.commit)
    else $error("edit not committed while unlocked");
  AST_ONE_ANSWER: assert property (
    ans_w |-> !(edit_rsp_out.commit && edit_rsp_out.refused) ##1 !ans_w)
    else $error("edit answer malformed or held");
  AST_ECHO: assert property (
    ans_w |-> edit_rsp_out.data == $past(edit_req_in.data, 2)
      && edit_rsp_out.is_freq == $past(edit_req_in.is_freq, 2)
      && edit_rsp_out.remote == $past(edit_req_in.remote, 2)
      && edit_rsp_out.addr == $past(edit_req_in.addr, 2))
    else $error("edit answer fields differ from request");
  AST_RSP_IDLE: assert property (!ans_w |-> edit_rsp_out == '0)
    else $error("edit answer fields not zero when idle");
  AST_RDATA_IDLE: assert property (!$past(reg_read_in) |-> reg_rdata_out == '0)
    else $error("read data not zero outside a read");
endmodule // pla_top_asserts

bind pla_top pla_top_asserts chk_u (.core_clk_in, .reset_in, .reg_read_in,
  .reg_rdata_out, .edit_req_in, .edit_ready_out, .edit_rsp_out,
  .param_edit_lock_out);

// ---- pla_pins_model.sv ----
// Model of the switch contacts that drive the intelligent inputs.
`include "pla_consts.svh"
module pla_pins_model (
  input  wire logic [`PLA_SLOTS-1:0] want_in,
  output logic      [`PLA_SLOTS-1:0] pins_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Contacts move off the clock grid so the synchroniser sees real skew.
  initial begin
    pins_out = '0;
    forever begin
      @(want_in);
      pins_out <= #3 want_in;
    end
  end
endmodule // pla_pins_model

// ---- pla_top_bench.sv ----
// Self-checking bench of the parameter lock and analog select block.
`include "pla_consts.svh"
module pla_top_bench import pla_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [3:0]    addr = '0;
  logic [15:0]   wdata = '0;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic [15:0]   rdata;
  logic [5:0]    want = '0;
  logic [5:0]    pins;
  logic [9:0]    vadc = '0;
  logic [9:0]    iadc = '0;
  pla_edit_req_s req = '0;
  logic          ready;
  pla_edit_rsp_s rsp;
  logic [10:0]   fref;
  logic          lock;
  int            n_mismatch = 0;
  int            checks_done = 0;
  int            cyc = 0;

  pla_pins_model pins_u (.want_in(want), .pins_out(pins));
  pla_top dut_u (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .input_pins_in(pins), .voltage_adc_in(vadc),
    .current_adc_in(iadc), .edit_req_in(req), .edit_ready_out(ready),
    .edit_rsp_out(rsp), .freq_ref_out(fref), .param_edit_lock_out(lock));

  initial forever #4 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wrr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(logic [3:0] a, logic [15:0] e, string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  // Lets two sync stages, the output register and the reference land.
  task automatic sett();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic ed(logic f, logic r, logic [15:0] d, logic c);
    @(posedge clk);
    req <= '{1'b1, r, f, 8'h21, d};
    @(posedge clk);
    req.valid <= 1'b0;
    @(posedge clk);
    #1 chk("answer", {14'h0, c, !c}, {14'h0, rsp.commit, rsp.refused});
    chk("echo", d, rsp.data);
  endtask
  task automatic fchk(logic [10:0] e, string nm);
    sett();
    chk(nm, {5'h0, e}, {5'h0, fref});
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdr(`PLA_OFS_SLOT0, 16'h001f, "slot0");
    rdr(`PLA_OFS_SLOT5, 16'h001f, "slot5");
    rdr(`PLA_OFS_CTRL, 16'h0004, "ctrl");
    wrr(4'h9, 16'hffff);
    rdr(4'h9, 16'h0000, "unmapped");
    rdr(`PLA_OFS_STATUS, 16'h0000, "status");
    ed(1'b0, 1'b0, 16'h1234, 1'b1);
    for (int s = 0; s < 6; s++) begin
      wrr(s[3:0], 16'h000f);
      want <= 6'h01 << s;
      sett();
      chk("lock", 16'h0001, {15'h0, lock});
      ed(1'b0, s[0], 16'h0100, 1'b0);
      ed(1'b1, s[0], 16'h0055 + 16'(s), 1'b1);
      want <= 6'h00;
      sett();
      chk("unlock", 16'h0000, {15'h0, lock});
      ed(1'b0, 1'b1, 16'h0200, 1'b1);
      wrr(s[3:0], 16'h001f);
    end
    rdr(`PLA_OFS_FREQ, 16'h005a, "freq word");
    wrr(`PLA_OFS_CTRL, 16'h0006);
    sett();
    chk("oplock", 16'h0001, {15'h0, lock});
    ed(1'b1, 1'b0, 16'h0123, 1'b1);
    ed(1'b0, 1'b0, 16'h0001, 1'b0);
    wrr(`PLA_OFS_CTRL, 16'h0007);
    sett();
    ed(1'b1, 1'b1, 16'h0321, 1'b0);
    rdr(`PLA_OFS_FREQ, 16'h0123, "freq kept");
    wrr(`PLA_OFS_CTRL, 16'h0005);
    sett();
    ed(1'b1, 1'b0, 16'h0456, 1'b1);
    wrr(`PLA_OFS_CTRL, 16'h0004);
    vadc <= 10'h3ff;
    iadc <= 10'h3fe;
    fchk(11'h7fd, "sum");
    wrr(4'h2, {11'h0, `PLA_FN_ASEL});
    fchk(11'h3ff, "volt");
    want <= 6'h04;
    fchk(11'h3fe, "curr");
    rdr(`PLA_OFS_STATUS, 16'h0006, "sel status");
    want <= 6'h00;
    fchk(11'h3ff, "release");
    wrr(`PLA_OFS_CTRL, 16'h0000);
    want <= 6'h04;
    fchk(11'h456, "word source");
    finish_test();
  end
endmodule // pla_top_bench
